// File: hdl/pmw_pkg.sv
// Overview of operation
// - Two-bit field selects full, wake, energy state
// - Byte-order test write wakes a sleeping device
// - Writes ignored until one read after wake
// - Control register stays readable while sleeping
// - Writing one resets transceiver for 100 us
// - Reset bit self-clears when transceiver leaves reset
// - Writes to reset bit ignored while set
// - Remote-wake event drives enabled wake pin
// - Remote-wake event raises interrupt despite pin enable
// - Energy-detect event drives enabled wake pin
// - Energy-detect event raises interrupt despite pin enable
// - Drive type: open-drain active low, or push-pull
// - Wake-cause field reports which enabled events occurred
// - Writing one clears a wake-cause bit
// - Cause clears only in full power, ready
// - Cause clears only once its source cleared
// - Pulse mode 50 ms, else continuous level
// - Polarity bit sets push-pull active level
// - Output enable gates pin, never interrupt
// - Ready bit shows device stable after wake
package pmw_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [31:0] PMC_OFF = 32'h84;
  localparam logic [31:0] BYTE_TEST_OFF = 32'h64;

  // ---------------------------------------------------------------
  // Field positions of the power management control register
  // ---------------------------------------------------------------
  localparam int STATE_LSB = 12;
  localparam int XCVR_RST_BIT = 10;
  localparam int REMOTE_WAKE_EN_BIT = 9;
  localparam int ENERGY_EN_BIT = 8;
  localparam int DRIVE_TYPE_BIT = 6;
  localparam int CAUSE_LSB = 4;
  localparam int PULSE_SEL_BIT = 3;
  localparam int POLARITY_BIT = 2;
  localparam int OUT_EN_BIT = 1;
  localparam int READY_BIT = 0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 250;
  localparam int XCVR_RST_TIME_US = 100;
  localparam int WAKE_PULSE_TIME_MS = 50;
  localparam int XCVR_RST_CYCLES = XCVR_RST_TIME_US * CLK_FREQ_MHZ;
  localparam int WAKE_PULSE_CYCLES = WAKE_PULSE_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam int READY_DELAY_CYCLES = 64;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FULL_POWER_STATE = 2'b00,
    WAKE_DETECT_STATE = 2'b01,
    ENERGY_DETECT_STATE = 2'b10,
    RESERVED_STATE = 2'b11
  } pmw_state_t;

  // Plain read/write configuration bits
  typedef struct packed {
    logic remoteWakeEnable;
    logic energyDetectEnable;
    logic driveType;
    logic pulseSelect;
    logic polarity;
    logic outputEnable;
  } pmw_cfg_t;

  localparam pmw_cfg_t CFG_RESET = '0;

endpackage : pmw_pkg

// File: hdl/pmw_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pmw_timer #(
  parameter int unsigned COUNT = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic start,
  output logic busy
);

  localparam int W = (COUNT > 1) ? $clog2(COUNT) : 1;
  localparam logic [W-1:0] LOAD = W'(COUNT - 1);

  logic [W-1:0] count_q;

  // ---------------------------------------------------------------
  // Busy for exactly COUNT cycles; a start while busy is ignored
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
      busy <= 1'b0;
    end else if (start && !busy) begin
      count_q <= LOAD;
      busy <= 1'b1;
    end else if (busy) begin
      if (count_q == '0) begin
        busy <= 1'b0;
      end else begin
        count_q <= count_q - W'(1);
      end
    end
  end

endmodule : pmw_timer
`default_nettype wire

// File: hdl/pmw_wake_control.sv
`timescale 1ns/1ps
`default_nettype none
module pmw_wake_control #(
  parameter int unsigned XCVR_RST_CYCLES = pmw_pkg::XCVR_RST_CYCLES,
  parameter int unsigned WAKE_PULSE_CYCLES = pmw_pkg::WAKE_PULSE_CYCLES,
  parameter int unsigned READY_DELAY_CYCLES = pmw_pkg::READY_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Event sources, level high while pending
  input wire logic remoteWakeSource,
  input wire logic energyDetectSource,
  // Power state and transceiver control
  output logic [1:0] powerStateSelect,
  output logic transceiverReset,
  // Wake outputs
  output logic wakeInterrupt,
  output logic wakeOutputPinOut,
  output logic wakeOutputPinOe
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  pmw_pkg::pmw_state_t powerState_q;
  pmw_pkg::pmw_cfg_t cfg_q;
  logic [1:0] wakeCause_q;
  logic writeArmed_q;
  logic bootDone_q;
  logic wrPmc_q;
  logic wrByteTest_q;
  logic wakeCondPrev_q;
  logic wakeInterrupt_q;
  logic pinOut_q;
  logic pinOe_q;
  logic [31:0] hrdata_q;

  logic addrPhase;
  logic hitPmc;
  logic hitByteTest;
  logic ready;
  logic writeOk;
  logic pmcWrite;
  logic wakeByWrite;
  logic [1:0] newState;
  logic xcvrStart;
  logic xcvrBusy;
  logic readyStart;
  logic readyBusy;
  logic pulseStart;
  logic pulseBusy;
  logic [1:0] causeSet;
  logic [1:0] causeClr;
  logic [1:0] causeSource;
  logic wakeCond;
  logic pinActive;
  logic [31:0] readValue;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // Zero wait states: every data phase completes in one cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign addrPhase = hsel && hready && htrans[1];
  assign hitPmc = (haddr == pmw_pkg::PMC_OFF);
  assign hitByteTest = (haddr == pmw_pkg::BYTE_TEST_OFF);

  // Latch the address phase of writes for the following data phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPmc_q <= 1'b0;
      wrByteTest_q <= 1'b0;
    end else if (hready) begin
      wrPmc_q <= addrPhase && hwrite && hitPmc;
      wrByteTest_q <= addrPhase && hwrite && hitByteTest;
    end
  end

  // ---------------------------------------------------------------
  // Ready and write gating
  // ---------------------------------------------------------------
  // Stable only in full power once the settle delay has run out
  assign ready = bootDone_q && !readyBusy &&
                 (powerState_q == pmw_pkg::FULL_POWER_STATE);

  // Writes while not ready are dropped, a misbehaving host cannot harm
  assign writeOk = writeArmed_q && ready;
  assign pmcWrite = wrPmc_q && writeOk;
  // Any data wakes a sleeping device; the byte-test write needs no arming
  assign wakeByWrite = wrByteTest_q &&
                       (powerState_q != pmw_pkg::FULL_POWER_STATE);

  // Kick the settle timer once after reset and again on every wake
  assign readyStart = !bootDone_q || wakeByWrite;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bootDone_q <= 1'b0;
    end else begin
      bootDone_q <= 1'b1;
    end
  end

  // A read arms writes; reset and each wake disarm them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      writeArmed_q <= 1'b0;
    end else if (wakeByWrite) begin
      writeArmed_q <= 1'b0;
    end else if (addrPhase && !hwrite) begin
      writeArmed_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Power state
  // ---------------------------------------------------------------
  assign newState = hwdata[pmw_pkg::STATE_LSB +: 2];

  // Reserved code is refused so the device never enters an undefined state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      powerState_q <= pmw_pkg::FULL_POWER_STATE;
    end else if (wakeByWrite) begin
      powerState_q <= pmw_pkg::FULL_POWER_STATE;
    end else if (pmcWrite && newState != 2'b11) begin
      case (newState)
        2'b01: powerState_q <= pmw_pkg::WAKE_DETECT_STATE;
        2'b10: powerState_q <= pmw_pkg::ENERGY_DETECT_STATE;
        default: powerState_q <= pmw_pkg::FULL_POWER_STATE;
      endcase
    end
  end

  assign powerStateSelect = powerState_q;

  // ---------------------------------------------------------------
  // Configuration bits
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= pmw_pkg::CFG_RESET;
    end else if (pmcWrite) begin
      cfg_q.remoteWakeEnable <= hwdata[pmw_pkg::REMOTE_WAKE_EN_BIT];
      cfg_q.energyDetectEnable <= hwdata[pmw_pkg::ENERGY_EN_BIT];
      cfg_q.driveType <= hwdata[pmw_pkg::DRIVE_TYPE_BIT];
      cfg_q.pulseSelect <= hwdata[pmw_pkg::PULSE_SEL_BIT];
      cfg_q.polarity <= hwdata[pmw_pkg::POLARITY_BIT];
      cfg_q.outputEnable <= hwdata[pmw_pkg::OUT_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Transceiver reset
  // ---------------------------------------------------------------
  // A one while the bit still reads one is dropped here, before it reaches the timer
  assign xcvrStart = pmcWrite && hwdata[pmw_pkg::XCVR_RST_BIT] &&
                     !xcvrBusy;

  // Held for the full interval, then the bit clears on its own
  pmw_timer #(
    .COUNT(XCVR_RST_CYCLES)
  ) u_xcvr_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(xcvrStart),
    .busy(xcvrBusy)
  );

  assign transceiverReset = xcvrBusy;

  // ---------------------------------------------------------------
  // Settle delay behind the ready bit
  // ---------------------------------------------------------------
  pmw_timer #(
    .COUNT(READY_DELAY_CYCLES)
  ) u_ready_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(readyStart),
    .busy(readyBusy)
  );

  // ---------------------------------------------------------------
  // Wake cause
  // ---------------------------------------------------------------
  // Bit 1 remote wake, bit 0 energy detect; both set reads as multiple
  assign causeSource = {remoteWakeSource, energyDetectSource};
  assign causeSet = {remoteWakeSource && cfg_q.remoteWakeEnable,
                     energyDetectSource && cfg_q.energyDetectEnable};
  // Clear needs ready, a one in the lane, and a quiet source
  assign causeClr = (pmcWrite ? hwdata[pmw_pkg::CAUSE_LSB +: 2] : 2'b00) &
                    ~causeSource;

  // A new event in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wakeCause_q <= 2'b00;
    end else begin
      wakeCause_q <= causeSet | (wakeCause_q & ~causeClr);
    end
  end

  // ---------------------------------------------------------------
  // Wake interrupt and wake pin
  // ---------------------------------------------------------------
  // Clearing either the cause or its enable removes the condition
  assign wakeCond = (wakeCause_q[1] && cfg_q.remoteWakeEnable) ||
                    (wakeCause_q[0] && cfg_q.energyDetectEnable);

  // Interrupt ignores the pin enable entirely
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wakeInterrupt_q <= 1'b0;
    end else begin
      wakeInterrupt_q <= wakeCond;
    end
  end

  assign wakeInterrupt = wakeInterrupt_q;

  // Pulse starts on the rising edge of the wake condition
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wakeCondPrev_q <= 1'b0;
    end else begin
      wakeCondPrev_q <= wakeCond;
    end
  end

  assign pulseStart = wakeCond && !wakeCondPrev_q && cfg_q.pulseSelect;

  pmw_timer #(
    .COUNT(WAKE_PULSE_CYCLES)
  ) u_pulse_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(pulseStart),
    .busy(pulseBusy)
  );

  // Pulse mode ends after the interval even if the cause lingers
  assign pinActive = cfg_q.outputEnable && wakeCond &&
                     (!cfg_q.pulseSelect || pulseBusy);

  // Open-drain pulls low only when active; push-pull always drives
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinOut_q <= 1'b0;
      pinOe_q <= 1'b0;
    end else if (!cfg_q.driveType) begin
      pinOut_q <= 1'b0;
      pinOe_q <= pinActive;
    end else begin
      pinOut_q <= cfg_q.polarity ? pinActive : !pinActive;
      pinOe_q <= 1'b1;
    end
  end

  assign wakeOutputPinOut = pinOut_q;
  assign wakeOutputPinOe = pinOe_q;

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Reserved positions stay zero; the register answers in any state
  always_comb begin
    readValue = 32'h0;
    readValue[pmw_pkg::STATE_LSB +: 2] = powerState_q;
    readValue[pmw_pkg::XCVR_RST_BIT] = xcvrBusy;
    readValue[pmw_pkg::REMOTE_WAKE_EN_BIT] = cfg_q.remoteWakeEnable;
    readValue[pmw_pkg::ENERGY_EN_BIT] = cfg_q.energyDetectEnable;
    readValue[pmw_pkg::DRIVE_TYPE_BIT] = cfg_q.driveType;
    readValue[pmw_pkg::CAUSE_LSB +: 2] = wakeCause_q;
    readValue[pmw_pkg::PULSE_SEL_BIT] = cfg_q.pulseSelect;
    readValue[pmw_pkg::POLARITY_BIT] = cfg_q.polarity;
    readValue[pmw_pkg::OUT_EN_BIT] = cfg_q.outputEnable;
    readValue[pmw_pkg::READY_BIT] = ready;
  end

  // Captured at the address phase so data stand through the data phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata_q <= 32'h0;
    end else if (addrPhase && !hwrite) begin
      hrdata_q <= hitPmc ? readValue : 32'h0;
    end
  end

endmodule : pmw_wake_control
`default_nettype wire

// File: bench/pmw_wake_control_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------
// Port checker for the wake control block
// ----------------------------------------------
module pmw_wake_control_properties #(
  parameter int unsigned XCVR_RST_CYCLES = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Events and outputs
  input wire logic remoteWakeSource,
  input wire logic energyDetectSource,
  input wire logic [1:0] powerStateSelect,
  input wire logic transceiverReset,
  input wire logic wakeInterrupt,
  input wire logic wakeOutputPinOut,
  input wire logic wakeOutputPinOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic rdTake;
  logic rdCtl;
  logic [31:0] xcvrCnt_q;
  // Read address phases; hrdata answers in the following cycle
  assign rdTake = hsel && hready && htrans[1] && !hwrite;
  assign rdCtl = rdTake && (haddr == pmw_pkg::PMC_OFF);
  // Length of the running transceiver reset, cleared when it drops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xcvrCnt_q <= 32'h0;
    end else begin
      xcvrCnt_q <= transceiverReset ? xcvrCnt_q + 32'h1 : 32'h0;
    end
  end
  AST_STATE_LEGAL: assert property (powerStateSelect != 2'b11)
    else $error("power state shows the reserved code");
  AST_XCVR_LEN: assert property (
    $fell(transceiverReset) |-> xcvrCnt_q == XCVR_RST_CYCLES)
    else $error("transceiver reset length wrong");
  AST_XCVR_MAX: assert property (xcvrCnt_q <= XCVR_RST_CYCLES)
    else $error("transceiver reset was stretched");
  AST_OD_LOW: assert property (
    !wakeOutputPinOe |-> !wakeOutputPinOut)
    else $error("wake pin undriven but output high");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus response not ready and okay");
  AST_RD_STABLE: assert property (!$past(rdTake) |-> $stable(hrdata))
    else $error("read data moved without a read");
  AST_RSV_ZERO: assert property ($past(rdCtl) |->
    hrdata[31:14] == 18'h0 && !hrdata[11] && !hrdata[7])
    else $error("reserved bits read nonzero");
  AST_OTHER_ZERO: assert property (
    $past(rdTake && !rdCtl) |-> hrdata == 32'h0)
    else $error("unmapped read returned data");
  AST_XCVR_SHOWN: assert property (
    $past(rdCtl) |-> hrdata[10] == $past(transceiverReset))
    else $error("reset bit differs from transceiver reset");
  AST_STATE_SHOWN: assert property (
    $past(rdCtl) |-> hrdata[13:12] == $past(powerStateSelect))
    else $error("state field differs from power state");
  // Main scenarios
  cover property ($rose(transceiverReset));
  cover property ($rose(wakeInterrupt));
  cover property (powerStateSelect == 2'b10);
endmodule : pmw_wake_control_properties
bind pmw_wake_control pmw_wake_control_properties #(
  .XCVR_RST_CYCLES(XCVR_RST_CYCLES)
) chk_u (
  .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .remoteWakeSource(remoteWakeSource),
  .energyDetectSource(energyDetectSource),
  .powerStateSelect(powerStateSelect),
  .transceiverReset(transceiverReset), .wakeInterrupt(wakeInterrupt),
  .wakeOutputPinOut(wakeOutputPinOut), .wakeOutputPinOe(wakeOutputPinOe)
);
`default_nettype wire

// File: bench/pmw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------
// Host processor: single-word bus master
// ----------------------------------------------
module pmw_host_model (
  // Clock
  input wire logic clk,
  // Bus master side
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  // Idle bus from time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // One transfer; a slow slave is simply waited for
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : pmw_host_model
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
  begin \
    testsRun++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
// ----------------------------------------------
// Bench for the wake control block
// ----------------------------------------------
module tb_top;
  typedef struct packed {logic [31:0] wr; logic [31:0] rd;} pmw_row_t;
  localparam int unsigned XCVR_N = 8;
  localparam int unsigned PULSE_N = 16;
  localparam int unsigned READY_N = 8;
  localparam logic [31:0] PMC = pmw_pkg::PMC_OFF;
  // Reserved state code and reserved bits must be dropped
  localparam pmw_row_t ROWS [3] = '{'{32'h0000_000e, 32'h0000_000f},
    '{32'hffff_b3f0, 32'h0000_0341}, '{32'h0, 32'h0000_0001}};
  int miscompares = 0;
  int testsRun = 0;
  logic clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [1:0] htrans, powerStateSelect;
  logic [2:0] hsize;
  logic remoteWakeSource, energyDetectSource, transceiverReset;
  logic wakeInterrupt, wakeOutputPinOut, wakeOutputPinOe;
  // Short counts keep the run brief
  pmw_wake_control #(.XCVR_RST_CYCLES(XCVR_N),
    .WAKE_PULSE_CYCLES(PULSE_N), .READY_DELAY_CYCLES(READY_N)) dut_u (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .remoteWakeSource(remoteWakeSource),
    .energyDetectSource(energyDetectSource),
    .powerStateSelect(powerStateSelect),
    .transceiverReset(transceiverReset), .wakeInterrupt(wakeInterrupt),
    .wakeOutputPinOut(wakeOutputPinOut), .wakeOutputPinOe(wakeOutputPinOe));
  pmw_host_model host_u (.clk(clk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));
  // Clock at 250 MHz
  initial clk = 1'b0;
  always #2 clk = ~clk;
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] unused;
    host_u.xfer(1'b1, a, d, unused);
  endtask : wr
  task automatic rd(input logic [31:0] a);
    host_u.xfer(1'b0, a, 32'h0, rdata);
  endtask : rd
  // Ends just after an edge so that its updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
  // Main sequence
  initial begin
    reset_n = 1'b0;
    remoteWakeSource = 1'b0;
    energyDetectSource = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    // Wait for ready before writing, but read nothing yet
    cyc(READY_N + 4);
    wr(PMC, 32'h2);
    rd(PMC);
    `CHECK(rdata, 32'h1)
    foreach (ROWS[i]) begin
      wr(PMC, ROWS[i].wr);
      rd(PMC);
      `CHECK(rdata, ROWS[i].rd)
    end
    wr(32'h88, 32'hffff_ffff);
    rd(32'h88);
    `CHECK(rdata, 32'h0)
    wr(PMC, 32'h400);
    rd(PMC);
    `CHECK(rdata, 32'h401)
    wr(PMC, 32'h400);
    cyc(XCVR_N);
    rd(PMC);
    `CHECK(rdata, 32'h1)
    // Level mode, open drain
    wr(PMC, 32'h302);
    @(posedge clk) remoteWakeSource <= 1'b1;
    cyc(3);
    `CHECK({wakeInterrupt, wakeOutputPinOe, wakeOutputPinOut}, 3'b110)
    @(posedge clk) remoteWakeSource <= 1'b0;
    rd(PMC);
    `CHECK(rdata, 32'h323)
    wr(PMC, 32'h322);
    cyc(2);
    `CHECK({wakeInterrupt, wakeOutputPinOe}, 2'b00)
    rd(PMC);
    `CHECK(rdata, 32'h303)
    @(posedge clk) energyDetectSource <= 1'b1;
    cyc(3);
    `CHECK({wakeOutputPinOe, wakeOutputPinOut}, 2'b10)
    // Pin disabled; the interrupt must still follow the events
    wr(PMC, 32'h300);
    cyc(2);
    `CHECK({wakeInterrupt, wakeOutputPinOe}, 2'b10)
    // Energy enable off, so only a remote wake can raise the interrupt
    wr(PMC, 32'h200);
    cyc(2);
    `CHECK(wakeInterrupt, 1'b0)
    @(posedge clk) remoteWakeSource <= 1'b1;
    cyc(3);
    `CHECK(wakeInterrupt, 1'b1)
    wr(PMC, 32'h300);
    @(posedge clk) remoteWakeSource <= 1'b0;
    rd(PMC);
    `CHECK(rdata, 32'h331)
    // Energy source pending with its enable off: its cause bit must stay
    wr(PMC, 32'h230);
    rd(PMC);
    `CHECK(rdata, 32'h211)
    @(posedge clk) energyDetectSource <= 1'b0;
    wr(PMC, 32'h310);
    rd(PMC);
    `CHECK(rdata, 32'h301)
    // Push-pull, active low, idles high
    wr(PMC, 32'h34a);
    cyc(2);
    `CHECK({wakeOutputPinOe, wakeOutputPinOut}, 2'b11)
    // Push-pull, active high, pulsed
    wr(PMC, 32'h34e);
    @(posedge clk) remoteWakeSource <= 1'b1;
    cyc(4);
    `CHECK({wakeOutputPinOe, wakeOutputPinOut}, 2'b11)
    cyc(PULSE_N);
    `CHECK({wakeOutputPinOe, wakeOutputPinOut}, 2'b10)
    @(posedge clk) remoteWakeSource <= 1'b0;
    wr(PMC, 32'h20);
    for (int s = 1; s < 3; s++) begin
      wr(PMC, {18'h0, s[1:0], 12'h0});
      cyc(2);
      `CHECK(powerStateSelect, s[1:0])
      rd(PMC);
      `CHECK(rdata, {18'h0, s[1:0], 12'h0})
      wr(32'h64, 32'hffff_ffff); // Only write while not ready
      cyc(2);
      `CHECK(powerStateSelect, 2'b00)
      cyc(READY_N + 4);
      wr(PMC, 32'h2);
      rd(PMC);
      `CHECK(rdata, 32'h1)
      wr(PMC, 32'h2);
      rd(PMC);
      `CHECK(rdata, 32'h3)
    end
    // Second reset in mid-run
    wr(PMC, 32'h400);
    @(posedge clk) reset_n <= 1'b0;
    cyc(2);
    `CHECK({transceiverReset, wakeInterrupt, wakeOutputPinOe}, 3'b000)
    @(posedge clk) reset_n <= 1'b1;
    rd(PMC);
    `CHECK(rdata, 32'h0)
    cyc(READY_N + 4);
    rd(PMC);
    `CHECK(rdata, 32'h1)
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
